// ===== src/hdlc_fault_pkg.sv
package hdlc_fault_pkg;

  // Interrupt descriptor codes; events and errors share one field.
  typedef enum logic [2:0] {
    CODE_NONE       = 3'h0,
    CODE_EOB        = 3'h1,
    CODE_EOM        = 3'h2,
    CODE_DUP_FILT   = 3'h3,
    CODE_OWNER      = 3'h4,
    CODE_XRUN       = 3'h5
  } int_code_e;

  typedef struct packed {
    int_code_e code;
    logic      dir;
  } int_desc_s;

  typedef struct packed {
    logic      owner_host;
    int_code_e error;
  } rx_status_s;

  // Transmit channel states, Gray coded along off, run, abort.
  typedef enum logic [1:0] {
    TX_OFF   = 2'b00,
    TX_RUN   = 2'b01,
    TX_ABORT = 2'b11,
    TX_FRAME_ALIGNMENT_CHANGE  = 2'b10
  } tx_state_e;

  localparam logic      DIR_RX          = 1'b0;
  localparam logic      DIR_TX          = 1'b1;
  localparam int        CLK_PERIOD_NS   = 20;
  localparam int        FRAME_ALIGNMENT_CHANGE_TIME_NS    = 125000;
  localparam int        FRAME_ALIGNMENT_CHANGE_CYCLES_DEF = FRAME_ALIGNMENT_CHANGE_TIME_NS / CLK_PERIOD_NS;
  localparam int        FRAME_ALIGNMENT_CHANGE_CNT_W      = 16;
  localparam logic [7:0] FRAME_BITS_T1  = 8'h00_C1;
  localparam logic [2:0] DUP_LEN_MIN    = 3'h3;
  localparam logic [2:0] DUP_LEN_MAX    = 3'h5;
  localparam int        MSG_BYTES       = 5;
  localparam int        SRC_N           = 7;
  localparam int        SRC_DUP         = 0;
  localparam int        SRC_TX_ONR      = 1;
  localparam int        SRC_TX_URUN     = 2;
  localparam int        SRC_RX_ONR      = 3;
  localparam int        SRC_RX_ORUN     = 4;
  localparam int        SRC_TX_EOB      = 5;
  localparam int        SRC_TX_EOM      = 6;

endpackage

// ===== src/hdlc_channel_fault_handler.sv
`timescale 1ns/100ps
// Functional notes
// - SS7: drop error-free 3 to 5 octet message equal to previous one.
// - Filtered duplicate posts duplicate_filtered, direction 0, unless masked.
// - Host-owned next descriptor mid message flags transmit owner underflow.
// - A granted buffer is used by the device until its end.
// - Transmit owner underflow posts descriptor_owner_fault, direction 1, unless masked.
// - Transmit fault sends continuous abort pattern of sixteen ones repeated.
// - After transmit owner underflow: no status write-back, polling off.
// - Transmit FIFO empty while shifting with buffer owned posts fifo_xrun_fault, aborts.
// - After transmit under-run: polling off, no status write-back.
// - Unexpected frame sync rise on T1/E1 ports is a frame alignment change.
// - Alignment change holds its mode for one 125 us frame period.
// - Alignment change aborts transmit, no descriptor update, no end events.
// - Alignment change stops descriptor polling, then deactivates the channel.
// - Host-owned next receive descriptor mid message posts descriptor_owner_fault, direction 0.
// - Receive owner overflow discards data, no status write-back, deactivates channel.
// - Receive overrun posts fifo_xrun_fault, direction 0, discards rest of message.
// - Receive overrun fetches next pointer and returns descriptor unless inhibited.
// - After overrun hunt next opening flag; DMA confirms ownership first.
module hdlc_channel_fault_handler
  import hdlc_fault_pkg::*;
#(
  parameter int FRAME_ALIGNMENT_CHANGE_CYCLES = hdlc_fault_pkg::FRAME_ALIGNMENT_CHANGE_CYCLES_DEF
) (
  input  wire logic                             clk,
  input  wire logic                             reset,
  input  wire logic                             link_clk,
  input  wire logic                             ss7_mode,
  input  wire logic                             t1e1_port,
  input  wire logic                             duplicate_filter_event_mask,
  input  wire logic                             tx_buffer_error_mask,
  input  wire logic                             rx_buffer_error_mask,
  input  wire logic                             inhibit_status_writeback,
  input  wire logic                             tx_activate,
  input  wire logic                             rx_activate,
  input  wire logic                             tx_desc_fetch,
  input  wire logic                             tx_desc_host_owned,
  input  wire logic                             tx_prev_end_of_message,
  input  wire logic                             tx_end_of_buffer,
  input  wire logic                             tx_end_of_message,
  input  wire logic                             rx_desc_fetch,
  input  wire logic                             rx_desc_host_owned,
  input  wire logic                             rx_in_message,
  input  wire logic                             tx_frame_sync,
  input  wire logic                             tx_bit_req,
  input  wire logic                             tx_fifo_empty,
  input  wire logic                             tx_buf_owned,
  input  wire logic                             tx_data_bit,
  input  wire logic                             rx_bit_valid,
  input  wire logic                             rx_fifo_full,
  input  wire logic                             rx_open_flag,
  input  wire logic                             rx_msg_done,
  input  wire logic                             rx_msg_ok,
  input  wire logic [2:0]                       rx_msg_len,
  input  wire logic [8*hdlc_fault_pkg::MSG_BYTES-1:0] rx_msg_data,
  output logic                                  int_valid,
  output hdlc_fault_pkg::int_desc_s             int_desc,
  output logic                                  tx_active,
  output logic                                  rx_active,
  output logic                                  tx_poll_enable,
  output logic                                  tx_status_wb_allow,
  output logic                                  rx_status_wb_valid,
  output hdlc_fault_pkg::rx_status_s            rx_status_wb,
  output logic                                  rx_next_ptr_fetch,
  output logic                                  rx_own_check,
  output logic                                  tx_serial_out,
  output logic                                  rx_discard,
  output logic                                  rx_msg_drop
);
  import hdlc_fault_pkg::*;

  // Lowest pending source wins; the queue takes one descriptor a cycle.
  function automatic logic [SRC_N-1:0] pick_one(input logic [SRC_N-1:0] p);
    logic [SRC_N-1:0] r;
    r = p & (~p + {{(SRC_N-1){1'b0}}, 1'b1});
    return r;
  endfunction

  function automatic int_desc_s src_desc(input logic [SRC_N-1:0] s);
    int_desc_s d;
    d = '{code: CODE_NONE, dir: DIR_RX};
    if (s[SRC_DUP])     d = '{code: CODE_DUP_FILT, dir: DIR_RX};
    if (s[SRC_TX_ONR])  d = '{code: CODE_OWNER,    dir: DIR_TX};
    if (s[SRC_TX_URUN]) d = '{code: CODE_XRUN,     dir: DIR_TX};
    if (s[SRC_RX_ONR])  d = '{code: CODE_OWNER,    dir: DIR_RX};
    if (s[SRC_RX_ORUN]) d = '{code: CODE_XRUN,     dir: DIR_RX};
    if (s[SRC_TX_EOB])  d = '{code: CODE_EOB,      dir: DIR_TX};
    if (s[SRC_TX_EOM])  d = '{code: CODE_EOM,      dir: DIR_TX};
    return d;
  endfunction

  // ---------------- Link domain ----------------
  logic       sync_meta_q, sync_q, sync_prev_q;
  logic [1:0] abort_sync_q, rxact_sync_q, ss7_sync_q, t1e1_sync_q;
  logic [7:0] frame_cnt_q;
  logic       frame_alignment_change_tgl_q, urun_tgl_q, orun_tgl_q, dup_tgl_q;
  logic       tx_serial_q, rx_discard_q, rx_drop_q;
  logic [2:0] prev_len_q;
  logic [8*MSG_BYTES-1:0] prev_data_q;
  logic       abort_l, rxact_l, dup_hit, urun_hit, orun_hit, sync_rise;
  // tx_poll_q and rx_active_q are read by the link logic, so these system-side flops are declared first.
  tx_state_e  tx_state_q;
  logic       rx_active_q, tx_poll_q;

  // The frame sync pin and all levels from the system side pass two flops.
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      sync_meta_q  <= 1'b0;
      sync_q       <= 1'b0;
      sync_prev_q  <= 1'b0;
      abort_sync_q <= 2'b11;
      rxact_sync_q <= 2'b00;
      ss7_sync_q   <= 2'b00;
      t1e1_sync_q  <= 2'b00;
    end else begin
      sync_meta_q  <= tx_frame_sync;
      sync_q       <= sync_meta_q;
      sync_prev_q  <= sync_q;
      // Only a single flop may cross, so the registered run level is used, not the state compare.
      abort_sync_q <= {abort_sync_q[0], ~tx_poll_q};
      rxact_sync_q <= {rxact_sync_q[0], rx_active_q};
      ss7_sync_q   <= {ss7_sync_q[0], ss7_mode};
      t1e1_sync_q  <= {t1e1_sync_q[0], t1e1_port};
    end
  end

  assign abort_l   = abort_sync_q[1];
  assign rxact_l   = rxact_sync_q[1];
  assign sync_rise = sync_q & ~sync_prev_q;
  assign urun_hit  = tx_bit_req & tx_fifo_empty & tx_buf_owned & ~abort_l;
  assign orun_hit  = rx_bit_valid & rx_fifo_full & rxact_l & ~rx_discard_q;
  assign dup_hit   = ss7_sync_q[1] & rx_msg_done & rx_msg_ok & rx_msg_len >= DUP_LEN_MIN &
                     rx_msg_len <= DUP_LEN_MAX & rx_msg_len == prev_len_q & rx_msg_data == prev_data_q;

  // Flywheel: a sync rise anywhere but the predicted bit is an alignment change.
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      frame_cnt_q <= 8'h00;
      frame_alignment_change_tgl_q  <= 1'b0;
    end else begin
      if (sync_rise || frame_cnt_q == FRAME_BITS_T1 - 8'h01) frame_cnt_q <= 8'h00;
      else frame_cnt_q <= frame_cnt_q + 8'h01;
      if (sync_rise && t1e1_sync_q[1] && frame_cnt_q != FRAME_BITS_T1 - 8'h01) begin
        frame_alignment_change_tgl_q <= ~frame_alignment_change_tgl_q;
      end
    end
  end

  // The abort pattern is sixteen ones repeated, so the line simply holds one.
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      tx_serial_q <= 1'b1;
      urun_tgl_q  <= 1'b0;
    end else begin
      tx_serial_q <= abort_l ? 1'b1 : tx_data_bit;
      if (urun_hit) urun_tgl_q <= ~urun_tgl_q;
    end
  end

  // Discard runs until the next opening flag while the channel is active.
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      rx_discard_q <= 1'b1;
      orun_tgl_q   <= 1'b0;
    end else begin
      if (!rxact_l) rx_discard_q <= 1'b1;
      else if (orun_hit) rx_discard_q <= 1'b1;
      else if (rx_open_flag) rx_discard_q <= 1'b0;
      if (orun_hit) orun_tgl_q <= ~orun_tgl_q;
    end
  end

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      prev_len_q  <= 3'h0;
      prev_data_q <= '0;
      rx_drop_q   <= 1'b0;
      dup_tgl_q   <= 1'b0;
    end else begin
      rx_drop_q <= dup_hit;
      if (dup_hit) dup_tgl_q <= ~dup_tgl_q;
      if (rx_msg_done && rx_msg_ok) begin
        prev_len_q  <= rx_msg_len;
        prev_data_q <= rx_msg_data;
      end
    end
  end

  // ---------------- System domain ----------------
  logic [2:0] frame_alignment_change_s_q, urun_s_q, orun_s_q, dup_s_q;
  logic       frame_alignment_change_ev, urun_ev, orun_ev, dup_ev, tx_onr_ev, rx_onr_ev;
  tx_state_e  tx_state_d;
  logic [FRAME_ALIGNMENT_CHANGE_CNT_W-1:0] frame_alignment_change_cnt_q;
  logic [SRC_N-1:0] pend_q, set_vec, serve;
  logic       int_valid_q, tx_wb_q;
  logic       rx_wb_valid_q, rx_next_q, rx_own_q;
  int_desc_s  int_desc_q;
  rx_status_s rx_wb_q;

  // Toggles from the link cross through two flops; the third flop marks the edge.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frame_alignment_change_s_q <= 3'h0;
      urun_s_q <= 3'h0;
      orun_s_q <= 3'h0;
      dup_s_q  <= 3'h0;
    end else begin
      frame_alignment_change_s_q <= {frame_alignment_change_s_q[1:0], frame_alignment_change_tgl_q};
      urun_s_q <= {urun_s_q[1:0], urun_tgl_q};
      orun_s_q <= {orun_s_q[1:0], orun_tgl_q};
      dup_s_q  <= {dup_s_q[1:0], dup_tgl_q};
    end
  end

  assign frame_alignment_change_ev   = frame_alignment_change_s_q[2] ^ frame_alignment_change_s_q[1];
  assign urun_ev   = (urun_s_q[2] ^ urun_s_q[1]) & tx_state_q == TX_RUN;
  assign orun_ev   = (orun_s_q[2] ^ orun_s_q[1]) & rx_active_q;
  assign dup_ev    = dup_s_q[2] ^ dup_s_q[1];
  assign tx_onr_ev = tx_state_q == TX_RUN & tx_desc_fetch & tx_desc_host_owned & ~tx_prev_end_of_message;
  assign rx_onr_ev = rx_active_q & rx_desc_fetch & rx_desc_host_owned & rx_in_message;

  always_comb begin
    tx_state_d = tx_state_q;
    case (tx_state_q)
      TX_OFF:   if (tx_activate) tx_state_d = TX_RUN;
      TX_RUN:   begin
        if (frame_alignment_change_ev) tx_state_d = TX_FRAME_ALIGNMENT_CHANGE;
        else if (tx_onr_ev || urun_ev) tx_state_d = TX_ABORT;
      end
      TX_ABORT: if (tx_activate) tx_state_d = TX_RUN;
      TX_FRAME_ALIGNMENT_CHANGE:  if (frame_alignment_change_cnt_q == '0) tx_state_d = TX_OFF;
      default:  tx_state_d = TX_OFF;
    endcase
  end

  // The hold restarts on each new alignment change, so the mode need not end on a frame edge.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_state_q <= TX_OFF;
      frame_alignment_change_cnt_q <= '0;
    end else begin
      tx_state_q <= tx_state_d;
      if (frame_alignment_change_ev) frame_alignment_change_cnt_q <= FRAME_ALIGNMENT_CHANGE_CNT_W'(FRAME_ALIGNMENT_CHANGE_CYCLES - 1);
      else if (frame_alignment_change_cnt_q != '0) frame_alignment_change_cnt_q <= frame_alignment_change_cnt_q - 1'b1;
    end
  end

  // Polling and transmit status write-back follow the run state only.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_poll_q <= 1'b0;
      tx_wb_q   <= 1'b0;
    end else begin
      tx_poll_q <= tx_state_d == TX_RUN;
      tx_wb_q   <= tx_state_d == TX_RUN;
    end
  end

  // Receive side: owner fault deactivates silently, overrun returns the descriptor.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_active_q   <= 1'b0;
      rx_wb_valid_q <= 1'b0;
      rx_wb_q       <= '{owner_host: 1'b1, error: CODE_NONE};
      rx_next_q     <= 1'b0;
      rx_own_q      <= 1'b0;
    end else begin
      if (rx_onr_ev) rx_active_q <= 1'b0;
      else if (rx_activate) rx_active_q <= 1'b1;
      rx_wb_valid_q <= orun_ev & ~inhibit_status_writeback & ~rx_onr_ev;
      rx_wb_q       <= '{owner_host: 1'b1, error: CODE_XRUN};
      rx_next_q     <= orun_ev & ~rx_onr_ev;
      if (orun_ev) rx_own_q <= 1'b1;
      else if (rx_desc_fetch && !rx_desc_host_owned) rx_own_q <= 1'b0;
    end
  end

  // Sources stay pending until served; a new set in the serving cycle wins.
  always_comb begin
    set_vec              = '0;
    set_vec[SRC_DUP]     = dup_ev & ~duplicate_filter_event_mask;
    set_vec[SRC_TX_ONR]  = tx_onr_ev & ~frame_alignment_change_ev & ~tx_buffer_error_mask;
    set_vec[SRC_TX_URUN] = urun_ev & ~frame_alignment_change_ev & ~tx_onr_ev & ~tx_buffer_error_mask;
    set_vec[SRC_RX_ONR]  = rx_onr_ev & ~rx_buffer_error_mask;
    set_vec[SRC_RX_ORUN] = orun_ev & ~rx_buffer_error_mask;
    set_vec[SRC_TX_EOB]  = tx_end_of_buffer & tx_state_q == TX_RUN;
    set_vec[SRC_TX_EOM]  = tx_end_of_message & tx_state_q == TX_RUN;
    serve                = pick_one(pend_q);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pend_q      <= '0;
      int_valid_q <= 1'b0;
      int_desc_q  <= '{code: CODE_NONE, dir: DIR_RX};
    end else begin
      pend_q      <= (pend_q & ~serve) | set_vec;
      int_valid_q <= |serve;
      int_desc_q  <= src_desc(serve);
    end
  end

  assign int_valid          = int_valid_q;
  assign int_desc           = int_desc_q;
  assign tx_active          = tx_poll_q;
  assign rx_active          = rx_active_q;
  assign tx_poll_enable     = tx_poll_q;
  assign tx_status_wb_allow = tx_wb_q;
  assign rx_status_wb_valid = rx_wb_valid_q;
  assign rx_status_wb       = rx_wb_q;
  assign rx_next_ptr_fetch  = rx_next_q;
  assign rx_own_check       = rx_own_q;
  assign tx_serial_out      = tx_serial_q;
  assign rx_discard         = rx_discard_q;
  assign rx_msg_drop        = rx_drop_q;

  // ---------------- Checks ----------------
  a_tx_onr_abort: assert property (@(posedge clk) disable iff (reset)
    tx_onr_ev && !frame_alignment_change_ev |=> tx_state_q == TX_ABORT)
    else $error("owner underflow did not abort");
  a_tx_onr_post: assert property (@(posedge clk) disable iff (reset)
    tx_onr_ev && !frame_alignment_change_ev && !tx_buffer_error_mask |-> ##[2:8] int_valid_q && int_desc_q.code == CODE_OWNER && int_desc_q.dir == DIR_TX)
    else $error("owner underflow not posted");
  a_abort_no_poll: assert property (@(posedge clk) disable iff (reset)
    tx_state_q == TX_ABORT |-> !tx_poll_q && !tx_wb_q)
    else $error("polling while aborted");
  a_abort_held: assert property (@(posedge clk) disable iff (reset)
    tx_state_q == TX_ABORT && !tx_activate |=> tx_state_q == TX_ABORT)
    else $error("abort left without reactivation");
  a_frame_alignment_change_end_off: assert property (@(posedge clk) disable iff (reset)
    tx_state_q == TX_FRAME_ALIGNMENT_CHANGE && frame_alignment_change_cnt_q == '0 |=> tx_state_q == TX_OFF && !tx_poll_q)
    else $error("channel not deactivated after alignment change");
  a_frame_alignment_change_hold_len: assert property (@(posedge clk) disable iff (reset)
    frame_alignment_change_ev |=> frame_alignment_change_cnt_q == FRAME_ALIGNMENT_CHANGE_CNT_W'(FRAME_ALIGNMENT_CHANGE_CYCLES - 1))
    else $error("alignment change hold length wrong");
  a_rx_onr_quiet: assert property (@(posedge clk) disable iff (reset)
    rx_onr_ev |=> !rx_active_q && !rx_wb_valid_q)
    else $error("owner overflow wrote status or stayed active");
  a_orun_return: assert property (@(posedge clk) disable iff (reset)
    orun_ev && !rx_onr_ev && !inhibit_status_writeback |=> rx_wb_valid_q && rx_next_q ##1 rx_wb_q.error == CODE_XRUN)
    else $error("overrun descriptor not returned");
  a_eom_suppressed: assert property (@(posedge clk) disable iff (reset)
    tx_state_q == TX_FRAME_ALIGNMENT_CHANGE |-> !set_vec[SRC_TX_EOB] && !set_vec[SRC_TX_EOM])
    else $error("end event during alignment change");
  a_abort_line: assert property (@(posedge link_clk) disable iff (reset)
    abort_l |=> tx_serial_q)
    else $error("abort pattern broken");
  a_dup_drop: assert property (@(posedge link_clk) disable iff (reset)
    dup_hit |=> rx_drop_q)
    else $error("duplicate not dropped");
  a_orun_discard: assert property (@(posedge link_clk) disable iff (reset)
    orun_hit |=> rx_discard_q)
    else $error("overrun data not discarded");

  c_tx_underrun: cover property (@(posedge clk) disable iff (reset) urun_ev ##[1:8] int_valid_q);
  c_frame_alignment_change_cycle: cover property (@(posedge clk) disable iff (reset) tx_state_q == TX_FRAME_ALIGNMENT_CHANGE ##1 tx_state_q == TX_OFF);
  c_dup_filter: cover property (@(posedge clk) disable iff (reset) dup_ev && !duplicate_filter_event_mask);
  c_rx_overrun: cover property (@(posedge clk) disable iff (reset) rx_wb_valid_q);

endmodule // hdlc_channel_fault_handler

// ===== tb/hdlc_link_model.sv
`timescale 1ns/100ps
module hdlc_link_model (
  input  wire logic        link_clk,
  output logic             tx_frame_sync,
  output logic             tx_bit_req,
  output logic             tx_fifo_empty,
  output logic             tx_buf_owned,
  output logic             tx_data_bit,
  output logic             rx_bit_valid,
  output logic             rx_fifo_full,
  output logic             rx_open_flag,
  output logic             rx_msg_done,
  output logic             rx_msg_ok,
  output logic [2:0]       rx_msg_len,
  output logic [39:0]      rx_msg_data
);
  int          seed = 32'h92231e22;
  logic [39:0] last_q = '0;
  // Buffers stay granted to the device; the host side never reclaims one.
  initial begin
    {tx_frame_sync, tx_fifo_empty, rx_fifo_full, rx_open_flag, rx_msg_done, rx_msg_ok} = '0;
    {tx_bit_req, tx_buf_owned, rx_bit_valid} = '1;
    tx_data_bit = 1'b0;
    rx_msg_len = 3'h0;
    rx_msg_data = '0;
  end
  always @(posedge link_clk) tx_data_bit <= #1 1'($random(seed));
  task automatic step();
    @(posedge link_clk);
    #1;
  endtask
  task automatic tx_underrun();
    step();
    tx_fifo_empty = 1'b1;
    step();
    tx_fifo_empty = 1'b0;
  endtask
  task automatic rx_overrun();
    step();
    rx_fifo_full = 1'b1;
    step();
    rx_fifo_full = 1'b0;
  endtask
  task automatic open_flag();
    step();
    rx_open_flag = 1'b1;
    step();
    rx_open_flag = 1'b0;
  endtask
  task automatic sync_rise();
    step();
    tx_frame_sync = 1'b1;
    repeat (3) step();
    tx_frame_sync = 1'b0;
  endtask
  // Unused upper bytes are zero, since the filter compares all forty bits.
  task automatic send_msg(input logic [2:0] len, input logic same);
    logic [39:0] d;
    d = 40'({$random(seed), $random(seed)}) & ((40'h1 << (8 * len)) - 40'h1);
    if (same) d = last_q;
    step();
    {rx_msg_len, rx_msg_data, rx_msg_ok, rx_msg_done} = {len, d, 2'b11};
    step();
    {rx_msg_data, rx_msg_ok, rx_msg_done} = {~d, 2'b00};
    last_q = d;
  endtask
endmodule // hdlc_link_model

// ===== tb/hdlc_channel_fault_handler_tb.sv
`timescale 1ns/100ps
module hdlc_channel_fault_handler_tb;
  import hdlc_fault_pkg::*;
  localparam int FRAME_ALIGNMENT_CHANGE_N = 20;
  logic clk = 0, link_clk = 0, reset = 1, ss7_mode = 0, t1e1_port = 0, duplicate_filter_event_mask = 0;
  logic tx_buffer_error_mask = 0, rx_buffer_error_mask = 0, inhibit_status_writeback = 0, tx_activate = 0;
  logic rx_activate = 0, tx_desc_fetch = 0, tx_desc_host_owned = 0, tx_prev_end_of_message = 0;
  logic tx_end_of_buffer = 0, tx_end_of_message = 0, rx_desc_fetch = 0, rx_desc_host_owned = 0, rx_in_message = 0;
  logic tx_frame_sync, tx_bit_req, tx_fifo_empty, tx_buf_owned, tx_data_bit, rx_bit_valid, rx_fifo_full;
  logic rx_open_flag, rx_msg_done, rx_msg_ok;
  logic [2:0] rx_msg_len;
  logic [39:0] rx_msg_data;
  logic int_valid, tx_active, rx_active, tx_poll_enable, tx_status_wb_allow, rx_status_wb_valid;
  logic rx_next_ptr_fetch, rx_own_check, tx_serial_out, rx_discard, rx_msg_drop;
  int_desc_s int_desc;
  rx_status_s rx_status_wb;
  int_desc_s expq[$];
  int fails = 0, total_checks = 0, wb_n = 0;
  hdlc_channel_fault_handler #(.FRAME_ALIGNMENT_CHANGE_CYCLES(FRAME_ALIGNMENT_CHANGE_N)) dut (.clk, .reset, .link_clk, .ss7_mode, .t1e1_port,
    .duplicate_filter_event_mask, .tx_buffer_error_mask, .rx_buffer_error_mask, .inhibit_status_writeback,
    .tx_activate, .rx_activate, .tx_desc_fetch, .tx_desc_host_owned, .tx_prev_end_of_message, .tx_end_of_buffer,
    .tx_end_of_message, .rx_desc_fetch, .rx_desc_host_owned, .rx_in_message, .tx_frame_sync, .tx_bit_req,
    .tx_fifo_empty, .tx_buf_owned, .tx_data_bit, .rx_bit_valid, .rx_fifo_full, .rx_open_flag, .rx_msg_done,
    .rx_msg_ok, .rx_msg_len, .rx_msg_data, .int_valid, .int_desc, .tx_active, .rx_active, .tx_poll_enable,
    .tx_status_wb_allow, .rx_status_wb_valid, .rx_status_wb, .rx_next_ptr_fetch, .rx_own_check, .tx_serial_out,
    .rx_discard, .rx_msg_drop);
  hdlc_link_model link (.link_clk, .tx_frame_sync, .tx_bit_req, .tx_fifo_empty, .tx_buf_owned, .tx_data_bit,
    .rx_bit_valid, .rx_fifo_full, .rx_open_flag, .rx_msg_done, .rx_msg_ok, .rx_msg_len, .rx_msg_data);
  initial forever #10 clk = ~clk;
  initial begin
    #7;
    forever #32 link_clk = ~link_clk;
  end
  task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  always @(posedge clk) begin
    if (!reset && int_valid === 1'b1) begin
      if (expq.size() == 0) chk("unexpected int", int_desc, 4'hf);
      else chk("int_desc", int_desc, expq.pop_front());
    end
    if (!reset && (rx_status_wb_valid | rx_next_ptr_fetch) === 1'b1) begin
      wb_n++;
      chk("next ptr", 4'(rx_next_ptr_fetch), 4'(rx_status_wb_valid));
      chk("rx status", rx_status_wb, {1'b1, CODE_XRUN});
    end
  end
  initial begin
    #400000;
    fails++;
    finish_test();
  end
  initial begin
    tick(6);
    reset = 0;
    pulse(tx_activate);
    tick(6);
    chk("poll on", 4'(tx_poll_enable), 4'h1);
    tx_desc_host_owned = 1;
    expq.push_back('{CODE_OWNER, DIR_TX});
    pulse(tx_desc_fetch);
    tick(2);
    chk("poll off", 4'({tx_poll_enable, tx_status_wb_allow}), 4'h0);
    repeat (3) @(posedge link_clk);
    repeat (16) begin
      @(posedge link_clk);
      #1;
      chk("abort ones", 4'(tx_serial_out), 4'h1);
    end
    pulse(tx_desc_fetch);
    tx_buffer_error_mask = 1;
    pulse(tx_activate);
    tick(6);
    pulse(tx_desc_fetch);
    tick(6);
    chk("masked abort", 4'(tx_poll_enable), 4'h0);
    {tx_buffer_error_mask, tx_desc_host_owned} = 2'b00;
    pulse(tx_activate);
    tick(14);
    expq.push_back('{CODE_XRUN, DIR_TX});
    link.tx_underrun();
    tick(10);
    chk("urun poll", 4'({tx_poll_enable, tx_status_wb_allow}), 4'h0);
    pulse(tx_activate);
    tick(6);
    expq.push_back('{CODE_EOM, DIR_TX});
    pulse(tx_end_of_message);
    t1e1_port = 1;
    tick(8);
    link.sync_rise();
    tick(10);
    chk("frame_alignment_change poll", 4'({tx_poll_enable, tx_active}), 4'h0);
    pulse(tx_end_of_buffer);
    tick(FRAME_ALIGNMENT_CHANGE_N + 10);
    t1e1_port = 0;
    pulse(tx_activate);
    tick(3);
    chk("frame_alignment_change over", 4'(tx_poll_enable), 4'h1);
    ss7_mode = 1;
    pulse(rx_activate);
    tick(6);
    for (int l = 3; l <= 6; l++) begin
      link.send_msg(3'(l), 1'b0);
      chk("new msg kept", 4'(rx_msg_drop), 4'h0);
      if (l < 6) expq.push_back('{CODE_DUP_FILT, DIR_RX});
      link.send_msg(3'(l), 1'b1);
      chk("dup drop", 4'(rx_msg_drop), 4'(l < 6));
      tick(12);
    end
    {ss7_mode, rx_in_message, rx_desc_host_owned} = 3'b011;
    expq.push_back('{CODE_OWNER, DIR_RX});
    pulse(rx_desc_fetch);
    tick(4);
    chk("onr deact", 4'(rx_active), 4'h0);
    chk("onr no wb", 4'(wb_n), 4'h0);
    {rx_in_message, rx_desc_host_owned} = 2'b00;
    pulse(rx_activate);
    tick(6);
    link.open_flag();
    expq.push_back('{CODE_XRUN, DIR_RX});
    link.rx_overrun();
    tick(10);
    chk("orun state", {rx_discard, rx_own_check, 2'(wb_n)}, 4'hd);
    pulse(rx_desc_fetch);
    tick(3);
    chk("own confirmed", 4'(rx_own_check), 4'h0);
    link.open_flag();
    tick(6);
    chk("hunt over", 4'(rx_discard), 4'h0);
    tick(10);
    chk("int queue", 4'(expq.size()), 4'h0);
    finish_test();
  end
endmodule // hdlc_channel_fault_handler_tb
